// ==== hdl/ctbc_pkg.sv ====
// What this block does
// - rising temperature steps class up, lowers limit
// - step down only below lower class threshold
// - classes zero to three use fixed codes
// - classes four to six, six suspends charging
// - derating starts above ninety degrees
// - charging suspended above one hundred fifteen
// - derating can be switched off
// - sagging rail in current limit lowers current
// - recovered rail or no limit ramps current up
// - safety timer starts on enable, programmable
// - reduced fast charge stretches timer inversely
// - stretch capped fifteenfold, fixed timer option
// - expiry raises interrupt, disables charging
// - backup current selectable in listed steps
// - backup termination 1.1 to 3.1 volts
// - backup stops at target, current below fifty
// - backup resumes 0.2 volts below target
// - backup charger off in no-power state
// - switch picks higher of rail and cell
// - cell disconnected from core rail at no-power
// - low target or disable blocks auto switch
// - switch hysteresis cell minus 0.2 volts
// - six-bit limit code, zero suspends
// - one bit enables thermal control
package ctbc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_TIMER  = 8'h04;
    localparam logic [7:0] ADDR_BACKUP = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_REMAIN = 8'h10;
    localparam logic [7:0] ADDR_IRQ    = 8'h14;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // control register layout, lsb last
    typedef struct packed {
        logic [5:0] cc_charge_current_code;
        logic       fast_mode;
        logic       auto_switch_enable;
        logic       fixed_timer;
        logic       charge_enable;
        logic       thermal_control_enable;
    } ctbc_ctrl_t;
    localparam logic [10:0] CTRL_RESET = 11'h7f9;

    // backup charger settings
    typedef struct packed {
        logic [4:0] target_sel;
        logic [3:0] current_sel;
    } ctbc_backup_t;
    localparam logic [8:0]  BACKUP_RESET = 9'h130;
    localparam logic [15:0] TIMER_RESET  = 16'h3840;

    // read-only status word
    typedef struct packed {
        logic       expired;
        logic       backup_on;
        logic       core_from_backup;
        logic [5:0] applied_code;
        logic [2:0] thermal_class;
    } ctbc_status_t;

    // thermal thresholds in degrees
    localparam logic [7:0] THERMAL_DERATE_THRESHOLD  = 8'h5a;
    localparam logic [7:0] THERMAL_SUSPEND_THRESHOLD = 8'h78;
    localparam logic [7:0] THERMAL_STEP              = 8'h05;
    // class limit codes, class 0 rightmost
    localparam logic [6:0][5:0] CLASS_CODE = {6'h00, 6'h0f,
        6'h19, 6'h23, 6'h2d, 6'h37, 6'h3f};

    // rail levels in millivolts, backup stop current in microamps
    localparam logic [11:0] DYNAMIC_CHARGE_CURRENT_CONTROL_LOW_MV     = 12'he10;
    localparam logic [11:0] DYNAMIC_CHARGE_CURRENT_CONTROL_HIGH_MV    = 12'hea6;
    localparam logic [11:0] BACKUP_HYST_MV  = 12'h0c8;
    localparam logic [11:0] BACKUP_BASE_MV  = 12'h44c;
    localparam logic [11:0] BACKUP_STEP_MV  = 12'h064;
    localparam logic [4:0]  BACKUP_SEL_MAX  = 5'h14;
    localparam logic [12:0] BACKUP_STOP_UA  = 13'h0032;
    localparam logic [11:0] CORE_SUPPLY_MV  = 12'h4b0;

    // timing
    localparam int CLOCK_HZ          = 25_000_000;
    localparam int TIMER_TICK_MS     = 1000;
    localparam int TIMER_TICK_CYCLES = CLOCK_HZ / 1000 * TIMER_TICK_MS;
    localparam int DYNAMIC_CHARGE_CURRENT_CONTROL_STEP_US      = 10;
    localparam int DYNAMIC_CHARGE_CURRENT_CONTROL_STEP_CYCLES  = CLOCK_HZ / 1_000_000 * DYNAMIC_CHARGE_CURRENT_CONTROL_STEP_US;
endpackage

// ==== hdl/ctbc_ctrl.sv ====
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ctbc_ctrl #(
    parameter int TICK_CYCLES = ctbc_pkg::TIMER_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // axi4-lite write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // adc and rail monitors, same clock
    input  wire logic [7:0]  die_temp,
    input  wire logic        die_temp_valid,
    input  wire logic [11:0] sys_rail_mv,
    input  wire logic [11:0] backup_cell_mv,
    input  wire logic [12:0] backup_current_ua,
    // asynchronous pins
    input  wire logic        buck_in_limit,
    input  wire logic        power_on_reset_n,
    // charger controls
    output logic [5:0]       applied_current_code,
    output logic             charge_enable,
    output logic             timer_irq,
    output logic [2:0]       thermal_class,
    // backup charger and battery switch
    output logic             backup_charge_on,
    output logic [3:0]       backup_current_sel,
    output logic [4:0]       backup_target_sel,
    output logic             core_from_backup
);
    ctbc_pkg::ctbc_ctrl_t   ctrl;
    ctbc_pkg::ctbc_backup_t backup;
    ctbc_pkg::ctbc_status_t status;
    logic [15:0] timer_period;
    logic [15:0] remaining;
    logic [5:0]  acc;
    logic        en_q;
    logic        expired;
    logic        expire_set;
    logic [5:0]  dynamic_charge_current_control;
    logic [5:0]  ceiling;
    logic [5:0]  class_code;
    logic [2:0]  temp_class;
    logic [7:0]  fall_thr;
    logic [1:0]  pin_meta;
    logic [1:0]  pin_sync;
    logic        lim_s;
    logic        por_s;
    logic        por_q;
    logic [31:0] tick_cnt;
    logic        tick;
    logic [7:0]  step_cnt;
    logic        dynamic_charge_current_control_tick;
    logic        aw_got;
    logic        w_got;
    logic        wr_fire;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [31:0] m_ctrl;
    logic [31:0] m_timer;
    logic [31:0] m_backup;
    logic [31:0] rd_word;
    logic        reduced;
    logic        step_due;
    logic [5:0]  rate;
    logic [6:0]  acc_sum;
    logic [5:0]  next_acc;
    logic        sag;
    logic        recover;
    logic [11:0] target_mv;
    logic        switch_allowed;

    // word match ignoring the byte lane bits
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, ctbc_pkg::ADDR_CTRL) ||
                 hit(a, ctbc_pkg::ADDR_TIMER) ||
                 hit(a, ctbc_pkg::ADDR_BACKUP) ||
                 hit(a, ctbc_pkg::ADDR_STATUS) ||
                 hit(a, ctbc_pkg::ADDR_REMAIN) ||
                 hit(a, ctbc_pkg::ADDR_IRQ);
    endfunction

    // byte-lane merge of a write into the old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                merge[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction

    // entry threshold of a class; class 0 reuses the first one
    function automatic logic [7:0] class_thr(input logic [2:0] k);
        if (k == 3'h0)
            class_thr = ctbc_pkg::THERMAL_DERATE_THRESHOLD;
        else
            class_thr = ctbc_pkg::THERMAL_DERATE_THRESHOLD
                + ctbc_pkg::THERMAL_STEP * {5'h00, k - 3'h1};
    endfunction

    // class that a temperature sample asks for
    function automatic logic [2:0] class_of(input logic [7:0] t);
        class_of = 3'h0;
        for (int k = 1; k < 7; k++)
        begin
            if (t > class_thr(3'(k)))
                class_of = 3'(k);
        end
        if (t >= ctbc_pkg::THERMAL_SUSPEND_THRESHOLD)
            class_of = 3'h6;
    endfunction

    // pins cross in through two flops before use
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end
        else
        begin
            pin_meta <= {buck_in_limit, power_on_reset_n};
            pin_sync <= pin_meta;
        end
    end
    assign lim_s = pin_sync[1];
    assign por_s = pin_sync[0];

    // second tick for the timer, short tick for current ramps
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            tick_cnt  <= 32'h0000_0000;
            tick      <= 1'b0;
            step_cnt  <= 8'h00;
            dynamic_charge_current_control_tick <= 1'b0;
        end
        else
        begin
            tick      <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt  <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
            dynamic_charge_current_control_tick <= (step_cnt == 8'(ctbc_pkg::DYNAMIC_CHARGE_CURRENT_CONTROL_STEP_CYCLES - 1));
            step_cnt  <= dynamic_charge_current_control_tick ? 8'h00 : step_cnt + 8'h01;
        end
    end

    // axi write: address and data taken in either order
    assign wr_fire = aw_got && w_got && !bvalid;
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            awready  <= 1'b1;
            wready   <= 1'b1;
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= ctbc_pkg::RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awready  <= 1'b0;
                aw_got   <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                wready  <= 1'b0;
                w_got   <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_fire)
            begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= mapped(awaddr_q) ? ctbc_pkg::RESP_OKAY
                                           : ctbc_pkg::RESP_SLVERR;
            end
            // channels reopen only after the response is taken
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // merged words for the writable registers
    always_comb
    begin
        m_ctrl   = merge({21'h00_0000, ctrl}, wdata_q, wstrb_q);
        m_timer  = merge({16'h0000, timer_period}, wdata_q, wstrb_q);
        m_backup = merge({23'h00_0000, backup}, wdata_q, wstrb_q);
    end

    // writable registers; out-of-range target codes clamp
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ctrl         <= ctbc_pkg::CTRL_RESET;
            backup       <= ctbc_pkg::BACKUP_RESET;
            timer_period <= ctbc_pkg::TIMER_RESET;
        end
        else if (wr_fire)
        begin
            if (hit(awaddr_q, ctbc_pkg::ADDR_CTRL))
                ctrl <= m_ctrl[10:0];
            if (hit(awaddr_q, ctbc_pkg::ADDR_TIMER))
                timer_period <= m_timer[15:0];
            if (hit(awaddr_q, ctbc_pkg::ADDR_BACKUP))
            begin
                backup.current_sel <= m_backup[3:0];
                backup.target_sel  <=
                    (m_backup[8:4] > ctbc_pkg::BACKUP_SEL_MAX) ?
                    ctbc_pkg::BACKUP_SEL_MAX : m_backup[8:4];
            end
        end
    end

    // sticky expiry flag; a new expiry beats a clear
    always_ff @(posedge clock)
    begin
        if (!rstn)
            timer_irq <= 1'b0;
        else if (expire_set)
            timer_irq <= 1'b1;
        else if (wr_fire && hit(awaddr_q, ctbc_pkg::ADDR_IRQ) &&
                 wstrb_q[0] && wdata_q[0])
            timer_irq <= 1'b0;
    end

    // read mux
    always_comb
    begin
        status  = {expired, backup_charge_on, core_from_backup,
                   applied_current_code, thermal_class};
        rd_word = 32'h0000_0000;
        if (hit(araddr, ctbc_pkg::ADDR_CTRL))
            rd_word = {21'h00_0000, ctrl};
        else if (hit(araddr, ctbc_pkg::ADDR_TIMER))
            rd_word = {16'h0000, timer_period};
        else if (hit(araddr, ctbc_pkg::ADDR_BACKUP))
            rd_word = {23'h00_0000, backup};
        else if (hit(araddr, ctbc_pkg::ADDR_STATUS))
            rd_word = {20'h0_0000, status};
        else if (hit(araddr, ctbc_pkg::ADDR_REMAIN))
            rd_word = {16'h0000, remaining};
        else if (hit(araddr, ctbc_pkg::ADDR_IRQ))
            rd_word = {31'h0000_0000, timer_irq};
    end

    // axi read: data one cycle after the address is taken
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= ctbc_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= mapped(araddr) ? ctbc_pkg::RESP_OKAY
                                      : ctbc_pkg::RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // thermal class, one step down per sample for hysteresis
    assign temp_class = class_of(die_temp);
    assign fall_thr   = class_thr(thermal_class - 3'h1);
    always_ff @(posedge clock)
    begin
        if (!rstn)
            thermal_class <= 3'h0;
        else if (!ctrl.thermal_control_enable)
            thermal_class <= 3'h0;
        else if (die_temp_valid)
        begin
            if (temp_class > thermal_class)
                thermal_class <= temp_class;
            else if (thermal_class != 3'h0 && die_temp < fall_thr)
                thermal_class <= thermal_class - 3'h1;
        end
    end

    // ceiling is the lower of class and host limits
    always_comb
    begin
        class_code = ctbc_pkg::CLASS_CODE[thermal_class];
        ceiling    = ctrl.cc_charge_current_code;
        if (ctrl.thermal_control_enable &&
            class_code < ctrl.cc_charge_current_code)
            ceiling = class_code;
    end

    // dynamic reduction ramps one code per step tick
    assign sag     = (sys_rail_mv <= ctbc_pkg::DYNAMIC_CHARGE_CURRENT_CONTROL_LOW_MV) && lim_s;
    assign recover = (sys_rail_mv > ctbc_pkg::DYNAMIC_CHARGE_CURRENT_CONTROL_HIGH_MV) || !lim_s;
    always_ff @(posedge clock)
    begin
        if (!rstn)
            dynamic_charge_current_control <= 6'h3f;
        else if (dynamic_charge_current_control > ceiling)
            dynamic_charge_current_control <= ceiling;
        else if (dynamic_charge_current_control_tick && sag && dynamic_charge_current_control != 6'h00)
            dynamic_charge_current_control <= dynamic_charge_current_control - 6'h01;
        else if (dynamic_charge_current_control_tick && recover && dynamic_charge_current_control < ceiling)
            dynamic_charge_current_control <= dynamic_charge_current_control + 6'h01;
    end

    // registered code to the analog loop; zero suspends
    always_ff @(posedge clock)
    begin
        if (!rstn)
            applied_current_code <= 6'h00;
        else
            applied_current_code <= dynamic_charge_current_control;
    end

    // timer stretch: count down at reduced/host, never below 1/15
    always_comb
    begin
        reduced  = ctrl.fast_mode && !ctrl.fixed_timer &&
                   ({dynamic_charge_current_control, 1'b0} < {1'b0, ctrl.cc_charge_current_code});
        rate     = (ctrl.cc_charge_current_code[5:3] == 3'h0) ? 6'h01
                   : {3'h0, ctrl.cc_charge_current_code[5:3]};
        if (dynamic_charge_current_control > rate)
            rate = dynamic_charge_current_control;
        acc_sum  = {1'b0, acc} + {1'b0, rate};
        step_due = !reduced ||
                   (acc_sum >= {1'b0, ctrl.cc_charge_current_code});
        next_acc = 6'h00;
        if (reduced && step_due)
            next_acc = 6'(acc_sum - {1'b0, ctrl.cc_charge_current_code});
        else if (reduced)
            next_acc = acc_sum[5:0];
    end

    // safety timer, loaded on the enable edge
    assign expire_set = ctrl.charge_enable && en_q && !expired &&
                        (remaining == 16'h0000);
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            en_q      <= 1'b0;
            expired   <= 1'b0;
            remaining <= 16'h0000;
            acc       <= 6'h00;
        end
        else
        begin
            en_q <= ctrl.charge_enable;
            if (!ctrl.charge_enable)
                expired <= 1'b0;
            else if (!en_q)
            begin
                remaining <= timer_period;
                acc       <= 6'h00;
            end
            else if (expire_set)
                expired <= 1'b1;
            else if (!expired && tick)
            begin
                acc <= next_acc;
                if (step_due)
                    remaining <= remaining - 16'h0001;
            end
        end
    end

    // charging stops in the cycle the timer expires
    always_ff @(posedge clock)
    begin
        if (!rstn)
            charge_enable <= 1'b0;
        else
            charge_enable <= ctrl.charge_enable && !expired &&
                             !expire_set;
    end

    // backup charger; starts charging when power returns
    assign target_mv = ctbc_pkg::BACKUP_BASE_MV + ctbc_pkg::BACKUP_STEP_MV
                       * {7'h00, backup.target_sel};
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            por_q            <= 1'b0;
            backup_charge_on <= 1'b0;
        end
        else
        begin
            por_q <= por_s;
            if (!por_s)
                backup_charge_on <= 1'b0;
            else if (!por_q)
                backup_charge_on <= 1'b1;
            else if (backup_charge_on && backup_cell_mv >= target_mv &&
                     backup_current_ua < ctbc_pkg::BACKUP_STOP_UA)
                backup_charge_on <= 1'b0;
            else if (!backup_charge_on && backup_cell_mv <
                     target_mv - ctbc_pkg::BACKUP_HYST_MV)
                backup_charge_on <= 1'b1;
        end
    end
    assign backup_current_sel = backup.current_sel;
    assign backup_target_sel  = backup.target_sel;

    // battery switch; a low target would back-feed the core rail
    assign switch_allowed = por_s && ctrl.auto_switch_enable &&
        (target_mv >= ctbc_pkg::CORE_SUPPLY_MV);
    always_ff @(posedge clock)
    begin
        if (!rstn)
            core_from_backup <= 1'b0;
        else if (!switch_allowed)
            core_from_backup <= 1'b0;
        else if (!core_from_backup && ({1'b0, sys_rail_mv} +
                 {1'b0, ctbc_pkg::BACKUP_HYST_MV} < {1'b0, backup_cell_mv}))
            core_from_backup <= 1'b1;
        else if (core_from_backup && sys_rail_mv > backup_cell_mv)
            core_from_backup <= 1'b0;
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_hot;
        die_temp_valid && ctrl.thermal_control_enable &&
        die_temp >= ctbc_pkg::THERMAL_SUSPEND_THRESHOLD;
    endsequence
    sequence s_expire;
        expire_set ##1 expired;
    endsequence

    a_thermal_rise: assert property (die_temp_valid &&
        ctrl.thermal_control_enable && temp_class > thermal_class
        |=> thermal_class == $past(temp_class))
        else $error("class did not rise to sample class");
    a_thermal_hyst: assert property (die_temp_valid &&
        ctrl.thermal_control_enable &&
        thermal_class != 3'h0 && temp_class <= thermal_class &&
        die_temp >= fall_thr |=> $stable(thermal_class))
        else $error("class fell inside hysteresis band");
    a_hot_suspend: assert property (s_hot |=>
        thermal_class == 3'h6 ##2 applied_current_code == 6'h00)
        else $error("hot die did not suspend charging");
    a_limit_ceiling: assert property (
        applied_current_code <= $past(ceiling, 2))
        else $error("applied code above ceiling");
    a_dynamic_charge_current_control_down: assert property (dynamic_charge_current_control_tick && sag &&
        dynamic_charge_current_control != 6'h00 && dynamic_charge_current_control <= ceiling
        |=> dynamic_charge_current_control == $past(dynamic_charge_current_control) - 6'h01)
        else $error("current not reduced on sag");
    a_dynamic_charge_current_control_up: assert property (dynamic_charge_current_control_tick && recover &&
        dynamic_charge_current_control < ceiling |=> dynamic_charge_current_control == $past(dynamic_charge_current_control) + 6'h01)
        else $error("current not ramped up");
    a_timer_expire: assert property (s_expire |->
        timer_irq && !charge_enable)
        else $error("expiry missed interrupt or disable");
    a_backup_nopor: assert property (!por_s |=>
        !backup_charge_on && !core_from_backup)
        else $error("backup active in no-power state");
    a_backup_resume: assert property (por_s && por_q &&
        !backup_charge_on &&
        backup_cell_mv < target_mv - ctbc_pkg::BACKUP_HYST_MV
        |=> backup_charge_on)
        else $error("backup charge did not resume");
    a_switch_block: assert property (!switch_allowed
        |=> !core_from_backup)
        else $error("switch connected while blocked");
    a_write_resp: assert property (wr_fire |=> bvalid && !awready)
        else $error("write response missing");
endmodule
`default_nettype wire

// ==== dv/ctbc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// host model: one axi4-lite write or read at a time
module ctbc_host (
    // clock and slave answers
    input  wire logic        clock, awready, wready, bvalid,
    input  wire logic        arready, rvalid,
    input  wire logic [1:0]  bresp, rresp,
    input  wire logic [31:0] rdata,
    // requests
    output logic             awvalid, wvalid, bready, arvalid, rready,
    output logic [7:0]       awaddr, araddr,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb
);
    // bus idle from time zero
    initial {awvalid, wvalid, bready, arvalid, rready} = '0;
    initial {awaddr, araddr, wdata, wstrb} = '0;
    // set when a write never answers or answers with an error
    bit wr_lost = 1'b0;
    // write: both channels offered, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        {awaddr, wdata, wstrb} <= {a, d, 4'hf};
        {awvalid, wvalid, bready} <= 3'b111;
        for (n = 0; n < 50 && (n == 0 || !bvalid); n++)
        begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        if (!bvalid || bresp !== 2'h0)
            wr_lost = 1'b1;
        bready <= 1'b0;
    endtask
    // read: a missing answer comes back as response 3
    task automatic rd(input logic [7:0] a, output logic [33:0] q);
        int n;
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (n = 0; n < 50 && (n == 0 || !rvalid); n++)
        begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end
        q = {rvalid ? rresp : 2'h3, rdata};
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // nets named as the ports they meet
    logic        clock = 1'b0, rstn = 1'b0;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, die_temp_valid;
    logic        buck_in_limit, power_on_reset_n, charge_enable;
    logic        timer_irq, backup_charge_on, core_from_backup;
    logic [7:0]  awaddr, araddr, die_temp;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, backup_current_sel;
    logic [1:0]  bresp, rresp;
    logic [11:0] sys_rail_mv, backup_cell_mv;
    logic [12:0] backup_current_ua;
    logic [5:0]  applied_current_code;
    logic [2:0]  thermal_class;
    logic [4:0]  backup_target_sel;
    logic [33:0] q;
    int          miscompares = 0, n_checks = 0, n;
    // short tick keeps the safety timer within reach
    ctbc_ctrl #(.TICK_CYCLES(10)) dut (.*);
    ctbc_host host (.*);
    always #20 clock = ~clock;
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [33:0] e);
        host.rd(a, q);
        chk(q, e);
    endtask
    // one adc result, then time for class and clamp
    task automatic ts(input logic [7:0] t, input logic [2:0] e);
        die_temp <= t;
        die_temp_valid <= 1'b1;
        @(posedge clock);
        die_temp_valid <= 1'b0;
        repeat (4) @(posedge clock);
        chk(thermal_class, e);
    endtask
    // rails and por pin; eight edges cover the pin sync flops
    task automatic bs(input logic [11:0] s, c, input logic p,
                      input logic [1:0] e);
        {sys_rail_mv, backup_cell_mv, power_on_reset_n} <= {s, c, p};
        repeat (8) @(posedge clock);
        chk({backup_charge_on, core_from_backup}, e);
    endtask
    task automatic final_report;
        if (host.wr_lost)
            miscompares++;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (30000) @(posedge clock);
        miscompares++;
        final_report();
    end
    initial
    begin
        {die_temp, die_temp_valid, buck_in_limit} = '0;
        {sys_rail_mv, backup_cell_mv} = {12'h0fa0, 12'h09c4};
        backup_current_ua = 13'h0190;
        power_on_reset_n = 1'b1;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        rchk(8'h00, 34'h0_0000_07f9);
        rchk(8'h18, 34'h2_0000_0000);
        host.wr(8'h08, 32'h0000_01f5);
        rchk(8'h08, 34'h0_0000_0145);
        chk({backup_target_sel, backup_current_sel}, 9'h145);
        $display("registers done");
        bs(12'h0fa0, 12'h09c4, 1'b1, 2'b10);
        backup_current_ua <= 13'h000a;
        bs(12'h0fa0, 12'h0c1c, 1'b1, 2'b00);
        backup_current_ua <= 13'h0190;
        bs(12'h0af0, 12'h0bea, 1'b1, 2'b01);
        bs(12'h0bb8, 12'h0bea, 1'b1, 2'b01);
        bs(12'h0c1c, 12'h0bea, 1'b1, 2'b00);
        bs(12'h0af0, 12'h09c4, 1'b0, 2'b00);
        host.wr(8'h08, 32'h0000_0005);
        bs(12'h01f4, 12'h0320, 1'b1, 2'b10);
        $display("backup done");
        ts(8'd93, 3'h1);
        chk(applied_current_code, 6'h37);
        ts(8'd101, 3'h3);
        chk(applied_current_code, 6'h23);
        ts(8'd97, 3'h3);
        ts(8'd94, 3'h2);
        ts(8'd112, 3'h5);
        chk(applied_current_code, 6'h0f);
        ts(8'd120, 3'h6);
        chk(applied_current_code, 6'h00);
        host.wr(8'h00, 32'h0000_07f8);
        ts(8'd120, 3'h0);
        $display("thermal done");
        host.wr(8'h04, 32'h0000_0002);
        host.wr(8'h00, 32'h0000_07ea);
        for (n = 0; n < 100 && timer_irq !== 1'b1; n++)
            @(posedge clock);
        chk({n > 9 && n < 41, charge_enable}, 2'b10);
        rchk(8'h14, 34'h0_0000_0001);
        host.wr(8'h14, 32'h0000_0001);
        rchk(8'h14, 34'h0_0000_0000);
        $display("timer done");
        for (n = 0; n < 3000 && applied_current_code < 6'h05; n++)
            @(posedge clock);
        chk(applied_current_code >= 6'h05, 1'b1);
        buck_in_limit <= 1'b1;
        sys_rail_mv   <= 12'h0e10;
        for (n = 0; n < 3000 && applied_current_code != 6'h00; n++)
            @(posedge clock);
        chk(applied_current_code, 6'h00);
        $display("dynamic_charge_current_control done");
        final_report();
    end
endmodule
`default_nettype wire
